// ==== adcu_consts.vh ====
`ifndef ADCU_CONSTS_VH
`define ADCU_CONSTS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADCU_RESULT_BASE 8'h00
`define ADCU_CSR_ADDR 8'h40
`define ADCU_START_ADDR 8'h44
`define ADCU_SEQ_ADDR 8'h48
// ----------------------------------------
// Control/status field positions
// ----------------------------------------
`define ADCU_CSR_END_FLAG 7
`define ADCU_CSR_IRQ_EN 6
`define ADCU_CSR_MODE_HI 5
`define ADCU_CSR_MODE_LO 4
`define ADCU_CSR_CHAN_HI 3
`define ADCU_START_RUN 0
// ----------------------------------------
// Reset values and modes
// ----------------------------------------
`define ADCU_CSR_RESET 8'h00
`define ADCU_RESULT_RESET 16'h0000
`define ADCU_MODE_SINGLE 2'h0
`define ADCU_MODE_SCAN4 2'h1
`define ADCU_MODE_SCAN8 2'h2
`define ADCU_MODE_SCAN12 2'h3
`define ADCU_RESP_OKAY 2'h0
`define ADCU_RESP_SLVERR 2'h2
`endif

// ==== adcu_seq.v ====
`default_nettype none
`include "adcu_consts.vh"
// Channel sequencer: chooses the next input to convert from mode and channel field
module adcu_seq (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_clr,
    input wire i_run,
    input wire [1:0] i_mode,
    input wire [3:0] i_chan,
    input wire i_conv_done,
    output reg [3:0] o_chan,
    output wire o_last_in_group,
    output wire o_last_in_scan
);
    // ----------------------------------------
    // Sequence position
    // ----------------------------------------
    reg [1:0] grp_r;
    reg [1:0] idx_r;
    wire [1:0] last_idx = i_chan[1:0];
    // Group 0 first in multi-group scans; chan bit 2 ignored there
    wire [1:0] grp_first = (i_mode == `ADCU_MODE_SCAN4) ? i_chan[3:2] : 2'h0;
    wire [1:0] grp_last = (i_mode == `ADCU_MODE_SCAN8) ? 2'h1 :
                          (i_mode == `ADCU_MODE_SCAN12) ? 2'h2 : grp_first;
    assign o_last_in_group = (i_mode == `ADCU_MODE_SINGLE) || (idx_r == last_idx);
    assign o_last_in_scan = o_last_in_group && (grp_r == grp_last);

    // Channel index output; single mode names the input directly
    always @* begin
        if (i_mode == `ADCU_MODE_SINGLE) begin
            o_chan = i_chan;
        end else begin
            o_chan = {grp_r, idx_r};
        end
    end

    // Advance on each finished conversion; wrap to start for repeating scan
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            grp_r <= 2'h0;
            idx_r <= 2'h0;
        end else if (i_clr || !i_run) begin
            grp_r <= grp_first;
            idx_r <= 2'h0;
        end else if (i_conv_done) begin
            if (o_last_in_scan) begin
                grp_r <= grp_first;
                idx_r <= 2'h0;
            end else if (o_last_in_group) begin
                grp_r <= grp_r + 2'h1;
                idx_r <= 2'h0;
            end else begin
                idx_r <= idx_r + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== adcu_top.v ====
// The AXI4-Lite slave port and the address map were decided locally.
`default_nettype none
`include "adcu_consts.vh"
module adcu_top (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_standby,
    // AXI4-Lite slave
    input wire [7:0] i_awaddr,
    input wire i_awvalid,
    output wire o_awready,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire i_wvalid,
    output wire o_wready,
    output reg [1:0] o_bresp,
    output reg o_bvalid,
    input wire i_bready,
    input wire [7:0] i_araddr,
    input wire i_arvalid,
    output wire o_arready,
    output reg [31:0] o_rdata,
    output reg [1:0] o_rresp,
    output reg o_rvalid,
    input wire i_rready,
    // Converter core
    output reg o_conv_start,
    output reg [3:0] o_conv_chan,
    input wire i_conv_done,
    input wire [9:0] i_conv_result,
    // Interrupt and DMA
    output wire o_unit0_end_irq,
    input wire i_dma_ack
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    reg [15:0] result_r [0:15];

    // Control/status fields and conversion state
    reg end_flag_r;
    reg irq_en_r;
    reg [1:0] mode_r;
    reg [3:0] chan_r;
    reg run_r;
    reg flag_seen_r;
    reg busy_r;
    reg [3:0] last_chan_r;

    // Bus holding registers
    reg aw_held_r;
    reg w_held_r;
    reg [7:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;

    // Sequencer links and standby synchroniser
    wire [3:0] seq_chan;
    wire seq_last_group;
    wire standby_sync;
    reg stby_meta_r;
    reg stby_sync_r;

    // ----------------------------------------
    // Standby synchroniser
    // ----------------------------------------
    // Standby pin comes from outside, two flops before use
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stby_meta_r <= 1'b0;
            stby_sync_r <= 1'b0;
        end else begin
            stby_meta_r <= i_standby;
            stby_sync_r <= stby_meta_r;
        end
    end
    assign standby_sync = stby_sync_r;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    adcu_seq u_seq (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_clr(standby_sync),
        .i_run(run_r),
        .i_mode(mode_r),
        .i_chan(chan_r),
        .i_conv_done(i_conv_done & busy_r),
        .o_chan(seq_chan),
        .o_last_in_group(seq_last_group),
        .o_last_in_scan() // Scan restart needs only the run bit here
    );

    // ----------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------
    // Address and data taken independently, response once both held
    assign o_awready = !aw_held_r && !o_bvalid;
    assign o_wready = !w_held_r && !o_bvalid;
    wire wr_fire = aw_held_r && w_held_r && !o_bvalid;

    // Held address decode; result registers accept writes and ignore them
    wire aw_is_csr = (aw_addr_r == `ADCU_CSR_ADDR);
    wire aw_is_start = (aw_addr_r == `ADCU_START_ADDR);
    wire aw_is_result = (aw_addr_r < `ADCU_CSR_ADDR);
    // Byte lane 0 carries every writable field
    wire csr_wr = wr_fire && aw_is_csr && w_strb_r[0];
    wire start_wr = wr_fire && aw_is_start && w_strb_r[0];
    wire wr_ok = aw_is_csr || aw_is_start || aw_is_result;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= `ADCU_RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= {i_awaddr[7:2], 2'b00};
            end
            if (i_wvalid && o_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= i_wdata;
                w_strb_r <= i_wstrb;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= wr_ok ? `ADCU_RESP_OKAY : `ADCU_RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------
    assign o_arready = !o_rvalid;
    wire rd_fire = i_arvalid && o_arready;
    wire [7:0] rd_addr = {i_araddr[7:2], 2'b00};
    wire csr_rd = rd_fire && (rd_addr == `ADCU_CSR_ADDR);
    wire [7:0] csr_val = {end_flag_r, irq_en_r, mode_r, chan_r};
    // Read decode; anything past the status word is refused
    wire rd_is_result = (rd_addr < `ADCU_CSR_ADDR);
    wire rd_is_start = (rd_addr == `ADCU_START_ADDR);
    wire rd_is_seq = (rd_addr == `ADCU_SEQ_ADDR);
    wire [5:0] seq_status = {busy_r, seq_last_group, last_chan_r};

    // Read mux; results use low word, upper bits zero
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= `ADCU_RESP_OKAY;
        end else if (rd_fire) begin
            o_rvalid <= 1'b1;
            o_rresp <= `ADCU_RESP_OKAY;
            if (rd_is_result) begin
                o_rdata <= {16'h0000, result_r[rd_addr[5:2]]};
            end else if (rd_addr == `ADCU_CSR_ADDR) begin
                o_rdata <= {24'h00_0000, csr_val};
            end else if (rd_is_start) begin
                o_rdata <= {31'h0000_0000, run_r};
            end else if (rd_is_seq) begin
                o_rdata <= {26'h000_0000, seq_status};
            end else begin
                o_rdata <= 32'h0000_0000;
                o_rresp <= `ADCU_RESP_SLVERR;
            end
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Control/status register
    // ----------------------------------------
    // Set beats clear: a group end in the same cycle as a clear keeps the flag
    // A done only counts while a conversion is ours; a late one after a stop drops
    wire conv_end = busy_r && i_conv_done;
    wire flag_set = conv_end && seq_last_group;
    wire sw_clr = csr_wr && !w_data_r[`ADCU_CSR_END_FLAG] && flag_seen_r;
    wire dma_clr = i_dma_ack && end_flag_r;
    // Only a read that saw the flag at one arms the clear
    wire csr_flag_rd = csr_rd && end_flag_r;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {end_flag_r, irq_en_r, mode_r, chan_r} <= `ADCU_CSR_RESET;
            flag_seen_r <= 1'b0;
        end else if (standby_sync) begin
            {end_flag_r, irq_en_r, mode_r, chan_r} <= `ADCU_CSR_RESET;
            flag_seen_r <= 1'b0;
        end else begin
            // Read-as-one arms the software clear
            if (csr_flag_rd) begin
                flag_seen_r <= 1'b1;
            end else if (sw_clr || !end_flag_r) begin
                flag_seen_r <= 1'b0;
            end
            if (flag_set) begin
                end_flag_r <= 1'b1;
            end else if (sw_clr || dma_clr) begin
                end_flag_r <= 1'b0;
            end
            if (csr_wr) begin
                irq_en_r <= w_data_r[`ADCU_CSR_IRQ_EN];
                mode_r <= w_data_r[`ADCU_CSR_MODE_HI:`ADCU_CSR_MODE_LO];
                chan_r <= w_data_r[`ADCU_CSR_CHAN_HI:0];
            end
        end
    end

    // ----------------------------------------
    // Interrupt and DMA request
    // ----------------------------------------
    // Request held as a level, so the DMA engine sees it as well
    assign o_unit0_end_irq = end_flag_r & irq_en_r;

    // ----------------------------------------
    // Run bit and conversion control
    // ----------------------------------------
    // Run value carried by a start register write
    wire run_wr_val = w_data_r[`ADCU_START_RUN];
    // Core pulse start, wait for done; run bit stays set in scan
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run_r <= 1'b0;
            busy_r <= 1'b0;
            o_conv_start <= 1'b0;
            o_conv_chan <= 4'h0;
            last_chan_r <= 4'h0;
        end else if (standby_sync) begin
            run_r <= 1'b0;
            busy_r <= 1'b0;
            o_conv_start <= 1'b0;
        end else begin
            o_conv_start <= 1'b0;
            if (busy_r && i_conv_done) begin
                busy_r <= 1'b0;
                last_chan_r <= o_conv_chan;
                if (mode_r == `ADCU_MODE_SINGLE) begin
                    run_r <= 1'b0;
                end
            end else if (run_r && !busy_r && !start_wr) begin
                busy_r <= 1'b1;
                o_conv_start <= 1'b1;
                o_conv_chan <= seq_chan;
            end
            // Software write wins over any automatic change
            if (start_wr) begin
                run_r <= run_wr_val;
                if (!run_wr_val) begin
                    busy_r <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Result registers
    // ----------------------------------------
    // Result word: ten bits left aligned, padding bits zero
    wire [15:0] result_word = {i_conv_result, 6'h00};
    // Store before the flag is seen: both land on the same edge
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_res
            always @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    result_r[gi] <= `ADCU_RESULT_RESET;
                end else if (standby_sync) begin
                    result_r[gi] <= `ADCU_RESULT_RESET;
                end else if (conv_end && o_conv_chan == gi) begin
                    result_r[gi] <= result_word;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ==== adcu_chk.sv ====
`default_nettype none
`include "adcu_consts.vh"
// ----------------------------------------
// Port checker for the converter unit
// ----------------------------------------
module adcu_chk (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_standby,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    input wire logic o_rvalid,
    input wire logic o_conv_start,
    input wire logic [3:0] o_conv_chan,
    input wire logic i_conv_done,
    input wire logic o_unit0_end_irq,
    input wire logic i_dma_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ar_q;
    logic busy_q;
    // Read address and conversion in flight, kept for the checks below
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ar_q <= 8'h00;
            busy_q <= 1'b0;
        end else begin
            if (i_arvalid && o_arready) ar_q <= i_araddr;
            if (o_conv_start) busy_q <= 1'b1;
            else if (i_conv_done) busy_q <= 1'b0;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_wr_both; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
    sequence s_stby; i_standby [*5]; endsequence
    // Both held one cycle, then the response register loads
    property p_wr_resp; s_wr_both |-> ##2 o_bvalid; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
    property p_rd_resp; i_arvalid && o_arready |=> o_rvalid; endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
    property p_rd_low; o_rvalid && ar_q < 8'h40 |-> !o_rdata[31:16] && !o_rdata[5:0]; endproperty
    a_rd_low: assert property (p_rd_low) else $error("result padding not zero");
    // Low address bits are dropped, so the status word spans 0x48 to 0x4b
    property p_rd_bad; o_rvalid && ar_q > 8'h4b |-> o_rresp == `ADCU_RESP_SLVERR && !o_rdata; endproperty
    a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not refused");
    // Irq may only appear from a finished conversion or a register write
    property p_irq_rise; $rose(o_unit0_end_irq) |-> $past(i_conv_done) || o_bvalid; endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
    property p_dma; i_dma_ack && !i_conv_done |=> !o_unit0_end_irq; endproperty
    a_dma: assert property (p_dma) else $error("dma ack left irq set");
    property p_one_conv; o_conv_start |-> !busy_q; endproperty
    a_one_conv: assert property (p_one_conv) else $error("start while converting");
    property p_chan_hold; busy_q && !o_conv_start |-> $stable(o_conv_chan); endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
    property p_stby; s_stby |-> !o_unit0_end_irq && !o_conv_start; endproperty
    a_stby: assert property (p_stby) else $error("standby did not clear");
endmodule
`default_nettype wire

// ==== tb.sv ====
`default_nettype none
// ----------------------------------------
// Bench for the converter register block
// ----------------------------------------
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rst_n, i_standby, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic i_dma_ack;
    logic i_conv_done = 1'b0, busy_c = 1'b0, st_s = 1'b0;
    logic [7:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata;
    logic [3:0] i_wstrb;
    logic [3:0] ch_s = 4'h0;
    logic [9:0] i_conv_result = 10'h000;
    wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_conv_start, o_unit0_end_irq;
    wire [1:0] o_bresp, o_rresp;
    wire [31:0] o_rdata;
    wire [3:0] o_conv_chan;
    int n_mismatch = 0, total_checks = 0, cyc = 0, irq_at = 0;
    logic [3:0] seen[$];
    logic [7:0] cs[3] = '{8'h16, 8'h25, 8'h71};
    logic [27:0] ex[3] = '{28'h0004654, 28'h0005410, 28'h0985410};
    int ln[3] = '{4, 5, 7};
    adcu_top i_dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_standby(i_standby),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
        .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .o_conv_start(o_conv_start), .o_conv_chan(o_conv_chan),
        .i_conv_done(i_conv_done), .i_conv_result(i_conv_result),
        .o_unit0_end_irq(o_unit0_end_irq), .i_dma_ack(i_dma_ack)
    );
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Outputs are sampled at the falling edge, where they match the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, pa, pw, bv;
        logic [1:0] br;
        pa = 1'b1;
        pw = 1'b1;
        bv = 1'b0;
        @(posedge i_clk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        while (!bv) begin
            @(negedge i_clk);
            ta = pa && o_awready;
            tw = pw && o_wready;
            bv = !pa && !pw && o_bvalid;
            br = o_bresp;
            @(posedge i_clk);
            if (ta) i_awvalid <= 1'b0;
            if (tw) i_wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        i_bready <= 1'b0;
        chk({30'h0, br}, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        logic ta, pa, rv;
        logic [31:0] d;
        logic [1:0] rr;
        pa = 1'b1;
        rv = 1'b0;
        @(posedge i_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        while (!rv) begin
            @(negedge i_clk);
            ta = pa && o_arready;
            rv = !pa && o_rvalid;
            d = o_rdata;
            rr = o_rresp;
            @(posedge i_clk);
            if (ta) i_arvalid <= 1'b0;
            pa = pa && !ta;
        end
        i_rready <= 1'b0;
        chk(d, e);
        chk({30'h0, rr}, {30'h0, r});
    endtask
    // Converter core: answers each start two cycles later with a channel-tagged value
    // An empty log marks a fresh scan, so the first-irq mark starts over there
    always @(negedge i_clk) begin
        st_s = o_conv_start;
        ch_s = o_conv_chan;
        if (seen.size() == 0) irq_at = 0;
        else if (o_unit0_end_irq && irq_at == 0) irq_at = seen.size();
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        busy_c <= st_s;
        i_conv_done <= busy_c && !st_s;
        if (st_s) seen.push_back(ch_s);
        if (busy_c && !st_s) i_conv_result <= {ch_s, 6'h2a};
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {i_rst_n, i_standby, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 7'h00;
        i_dma_ack = 1'b0;
        {i_awaddr, i_araddr, i_wdata} = '0;
        i_wstrb = 4'hf;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(8'h40, 32'h0, 2'h0);
        rd(8'h14, 32'h0, 2'h0);
        rd(8'h50, 32'h0, 2'h2);
        wr(8'h40, 32'h80);
        rd(8'h40, 32'h0, 2'h0);
        wr(8'h40, 32'h49);
        wr(8'h44, 32'h1);
        repeat (30) @(posedge i_clk);
        chk(seen.size(), 1);
        chk({28'h0, seen[0]}, 32'h9);
        rd(8'h24, {16'h0, 4'h9, 6'h2a, 6'h0}, 2'h0);
        rd(8'h40, 32'hc9, 2'h0);
        rd(8'h44, 32'h0, 2'h0);
        rd(8'h48, 32'h19, 2'h0);
        @(negedge i_clk);
        chk(o_unit0_end_irq, 1);
        wr(8'h40, 32'h49);
        rd(8'h40, 32'h49, 2'h0);
        @(negedge i_clk);
        chk(o_unit0_end_irq, 0);
        // Scan modes: 4-channel group 1, 8-channel with bit 2 set, 12-channel
        for (int k = 0; k < 3; k++) begin
            wr(8'h40, {24'h0, cs[k]});
            seen.delete();
            wr(8'h44, 32'h1);
            while (seen.size() < ln[k]) @(posedge i_clk);
            rd(8'h44, 32'h1, 2'h0);
            wr(8'h44, 32'h0);
            repeat (4) @(posedge i_clk);
            for (int j = 0; j < ln[k]; j++) begin
                chk({28'h0, seen[j]}, {28'h0, ex[k][4*j +: 4]});
            end
            chk(irq_at, k == 2 ? 2 : 0);
            rd(8'h40, {24'h0, cs[k] | 8'h80}, 2'h0);
        end
        // DMA clear, then standby wipe with the flag raised
        wr(8'h40, 32'h42);
        wr(8'h44, 32'h1);
        while (!o_unit0_end_irq) @(negedge i_clk);
        @(posedge i_clk);
        i_dma_ack <= 1'b1;
        @(posedge i_clk);
        i_dma_ack <= 1'b0;
        rd(8'h40, 32'h42, 2'h0);
        wr(8'h44, 32'h1);
        while (!o_unit0_end_irq) @(negedge i_clk);
        @(posedge i_clk);
        i_standby <= 1'b1;
        repeat (8) @(posedge i_clk);
        i_standby <= 1'b0;
        repeat (3) @(posedge i_clk);
        rd(8'h08, 32'h0, 2'h0);
        rd(8'h40, 32'h0, 2'h0);
        close_out();
    end
endmodule
bind adcu_top adcu_chk i_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_standby(i_standby),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bvalid(o_bvalid), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .o_conv_start(o_conv_start), .o_conv_chan(o_conv_chan), .i_conv_done(i_conv_done),
    .o_unit0_end_irq(o_unit0_end_irq), .i_dma_ack(i_dma_ack)
);
`default_nettype wire
